// [verilog/spc_pkg.sv]
// package: constants, register map and types of the stop-mode power controller
// Function
// - writing 1 to stop bit (bit 1, power control register) enters stop mode
// - execution halts right after the write that sets the stop bit
// - in stop mode all on-chip clocks, timers and serial activity halt
// - any enabled one of six external interrupt inputs going active exits stop
// - external reset pin exits stop unconditionally
// - bandgap select 1: supply below trip level in stop generates a reset
// - bandgap select 0: no reset in stop from low supply
// - after stop, wait 65,536 cycles of flash warm-up before executing
// - without ring oscillator, also wait out crystal warm-up before executing
// - ring select bit (bit 1, irq flag register) runs from ring until crystal ready
// - ring select 0: execution delayed 65,536 crystal periods after stop
// - readable ring-mode status bit shows current clock source
// - while on ring, clock divide bits held at 10b, writes ignored
`default_nettype none

package spc_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int         ADDR_W             = 4;
	localparam int         DATA_W             = 8;
	localparam logic [3:0] REG_PWR_CTRL       = 4'h0;
	localparam logic [3:0] REG_IRQ_FLAG       = 4'h1;
	localparam logic [3:0] REG_IRQ_EN         = 4'h2;
	localparam logic [3:0] REG_CLK_DIV        = 4'h3;

	localparam int         PWR_STOP_BIT       = 1;
	localparam int         PWR_BGS_BIT        = 6;
	localparam int         FLAG_RING_SEL_BIT  = 1;
	localparam int         FLAG_RING_MODE_BIT = 3;

	localparam int         N_IRQ              = 6;
	localparam logic [5:0] IRQ_EN_RST         = 6'h00;
	localparam logic [5:0] IRQ_HIGH_ACTIVE    = 6'h14;
	localparam logic [1:0] CLK_DIV_BY1        = 2'h2;

	// ----------------------------------------
	// timing counts in core clock cycles
	// ----------------------------------------
	localparam int         CNT_W              = 17;
	localparam int         FLASH_WARM_CYCLES  = 65536;
	localparam int         XTAL_WARM_CYCLES   = 65536;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_STOP = 3'b010,
		ST_WARM = 3'b100
	} spc_state_e_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} spc_bus_req_t;

	typedef struct packed {
		spc_state_e_t      st;
		logic              stop_bit;
		logic              bgs_bit;
		logic              ring_sel;
		logic              ring_mode;
		logic [5:0]        irq_en;
		logic [1:0]        clk_div;
		logic [CNT_W-1:0]  flash_cnt;
		logic [CNT_W-1:0]  xtal_cnt;
		logic              clk_run_en;
		logic              cpu_run;
		logic              xtal_en;
		logic              sys_reset;
		logic [DATA_W-1:0] rdata;
	} spc_core_t;

endpackage : spc_pkg

`default_nettype wire

// [verilog/spc_sync.sv]
// two-flop synchroniser for pin inputs
`default_nettype none

module spc_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} spc_sync_t;

	spc_sync_t s_q;
	spc_sync_t s_d;

	always_comb begin
		s_d        = s_q;
		s_d.meta   = d;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.stable;

endmodule : spc_sync

`default_nettype wire

// [verilog/spc_stop_ctrl.sv]
// stop-mode power controller: register port, stop/wake sequencing, warm-up counts
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`default_nettype none

module spc_stop_ctrl #(
	parameter int         FLASH_CYCLES = spc_pkg::FLASH_WARM_CYCLES,
	parameter int         XTAL_CYCLES  = spc_pkg::XTAL_WARM_CYCLES,
	parameter logic [5:0] IRQ_HIGH     = spc_pkg::IRQ_HIGH_ACTIVE
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire spc_pkg::spc_bus_req_t      bus_req,
	output var  logic [spc_pkg::DATA_W-1:0] bus_rdata,
	input  wire logic [5:0]                 ext_irq_pin,
	input  wire logic                       rst_pin,
	input  wire logic                       supply_low,
	output var  logic                       clk_run_en,
	output var  logic                       cpu_run,
	output var  logic                       xtal_en,
	output var  logic                       ring_osc_en,
	output var  logic                       clk_from_ring,
	output var  logic                       sys_reset,
	output var  logic [1:0]                 clk_div
);

	localparam logic [spc_pkg::CNT_W-1:0] FLASH_LOAD = spc_pkg::CNT_W'(FLASH_CYCLES - 1);
	localparam logic [spc_pkg::CNT_W-1:0] XTAL_LOAD  = spc_pkg::CNT_W'(XTAL_CYCLES - 1);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [7:0] pins_s;

	spc_sync #(.W(8)) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.d        ({supply_low, rst_pin, ext_irq_pin}),
		.q        (pins_s)
	);

	logic [5:0] irq_s;
	logic       rst_pin_s;
	logic       low_s;

	assign irq_s     = pins_s[5:0];
	assign rst_pin_s = pins_s[6];
	assign low_s     = pins_s[7];

	function automatic logic irq_active(input logic [5:0] lvl, input logic [5:0] en, input logic [5:0] hi);
		irq_active = |(en & ~(lvl ^ hi));
	endfunction : irq_active

	function automatic logic [spc_pkg::CNT_W-1:0] dec_sat(input logic [spc_pkg::CNT_W-1:0] c);
		dec_sat = (c == '0) ? c : c - spc_pkg::CNT_W'(1);
	endfunction : dec_sat

	// ----------------------------------------
	// state
	// ----------------------------------------
	spc_pkg::spc_core_t c_q;
	spc_pkg::spc_core_t c_d;

	logic irq_hit;
	logic bg_reset;
	logic stop_wr;

	assign irq_hit  = irq_active(irq_s, c_q.irq_en, IRQ_HIGH);
	assign bg_reset = c_q.bgs_bit & low_s;
	assign stop_wr  = bus_req.wr && bus_req.addr == spc_pkg::REG_PWR_CTRL && bus_req.wdata[spc_pkg::PWR_STOP_BIT];

	always_comb begin
		c_d           = c_q;
		c_d.rdata     = '0;
		c_d.sys_reset = 1'b0;

		// register writes
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				spc_pkg::REG_PWR_CTRL: begin
					c_d.stop_bit = bus_req.wdata[spc_pkg::PWR_STOP_BIT];
					c_d.bgs_bit  = bus_req.wdata[spc_pkg::PWR_BGS_BIT];
				end
				spc_pkg::REG_IRQ_FLAG: c_d.ring_sel = bus_req.wdata[spc_pkg::FLAG_RING_SEL_BIT];
				spc_pkg::REG_IRQ_EN: c_d.irq_en = bus_req.wdata[5:0];
				spc_pkg::REG_CLK_DIV: begin
					if (!c_q.ring_mode) begin
						c_d.clk_div = bus_req.wdata[1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// register reads, data in the following cycle only
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				spc_pkg::REG_PWR_CTRL: begin
					c_d.rdata[spc_pkg::PWR_STOP_BIT] = c_q.stop_bit;
					c_d.rdata[spc_pkg::PWR_BGS_BIT]  = c_q.bgs_bit;
				end
				spc_pkg::REG_IRQ_FLAG: begin
					c_d.rdata[spc_pkg::FLAG_RING_SEL_BIT]  = c_q.ring_sel;
					c_d.rdata[spc_pkg::FLAG_RING_MODE_BIT] = c_q.ring_mode;
				end
				spc_pkg::REG_IRQ_EN: c_d.rdata[5:0] = c_q.irq_en;
				spc_pkg::REG_CLK_DIV: c_d.rdata[1:0] = c_q.clk_div;
				default: c_d.rdata = '0;
			endcase
		end

		// crystal warm-up runs whenever the crystal is on
		if (c_q.xtal_en) begin
			c_d.xtal_cnt = dec_sat(c_q.xtal_cnt);
		end
		if (c_q.ring_mode && c_q.xtal_cnt == '0) begin
			c_d.ring_mode = 1'b0;
		end

		unique case (c_q.st)
			spc_pkg::ST_RUN: begin
				if (rst_pin_s) begin
					c_d.sys_reset = 1'b1;
					c_d.stop_bit  = 1'b0;
					c_d.bgs_bit   = 1'b0;
					c_d.ring_sel  = 1'b0;
					c_d.irq_en    = spc_pkg::IRQ_EN_RST;
					c_d.clk_div   = spc_pkg::CLK_DIV_BY1;
				end else if (stop_wr) begin
					c_d.st         = spc_pkg::ST_STOP;
					c_d.cpu_run    = 1'b0;
					c_d.clk_run_en = 1'b0;
					c_d.xtal_en    = 1'b0;
					c_d.ring_mode  = 1'b0;
				end
			end
			spc_pkg::ST_STOP: begin
				if (rst_pin_s || bg_reset || irq_hit) begin
					c_d.st         = spc_pkg::ST_WARM;
					c_d.stop_bit   = 1'b0;
					c_d.sys_reset  = rst_pin_s | bg_reset;
					c_d.clk_run_en = 1'b1;
					c_d.xtal_en    = 1'b1;
					c_d.flash_cnt  = FLASH_LOAD;
					c_d.xtal_cnt   = XTAL_LOAD;
					c_d.ring_mode  = c_q.ring_sel;
					if (c_q.ring_sel) begin
						c_d.clk_div = spc_pkg::CLK_DIV_BY1;
					end
				end
			end
			spc_pkg::ST_WARM: begin
				c_d.sys_reset = rst_pin_s;
				c_d.flash_cnt = dec_sat(c_q.flash_cnt);
				if (c_q.flash_cnt == '0 && (c_q.ring_sel || c_q.xtal_cnt == '0)) begin
					c_d.st      = spc_pkg::ST_RUN;
					c_d.cpu_run = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			c_q            <= '0;
			c_q.st         <= spc_pkg::ST_RUN;
			c_q.irq_en     <= spc_pkg::IRQ_EN_RST;
			c_q.clk_div    <= spc_pkg::CLK_DIV_BY1;
			c_q.clk_run_en <= 1'b1;
			c_q.cpu_run    <= 1'b1;
			c_q.xtal_en    <= 1'b1;
		end else begin
			c_q <= c_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bus_rdata     = c_q.rdata;
	assign clk_run_en    = c_q.clk_run_en;
	assign cpu_run       = c_q.cpu_run;
	assign xtal_en       = c_q.xtal_en;
	assign ring_osc_en   = c_q.ring_mode;
	assign clk_from_ring = c_q.ring_mode;
	assign sys_reset     = c_q.sys_reset;
	assign clk_div       = c_q.clk_div;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	stop_entry_a: assert property (c_q.st == spc_pkg::ST_RUN && !rst_pin_s && stop_wr |=> c_q.st == spc_pkg::ST_STOP && c_q.stop_bit) else $error("stop not entered");
	halt_now_a: assert property (c_q.st == spc_pkg::ST_RUN && !rst_pin_s && stop_wr |=> !cpu_run) else $error("execution not halted");
	clocks_off_a: assert property (c_q.st == spc_pkg::ST_STOP |-> !clk_run_en && !xtal_en && !cpu_run && !ring_osc_en) else $error("clocks running in stop");
	irq_wake_a: assert property (c_q.st == spc_pkg::ST_STOP && irq_hit |=> c_q.st == spc_pkg::ST_WARM) else $error("interrupt did not wake");
	pin_wake_a: assert property (c_q.st == spc_pkg::ST_STOP && rst_pin_s |=> c_q.st == spc_pkg::ST_WARM && sys_reset) else $error("reset pin did not wake");
	bg_reset_a: assert property (c_q.st == spc_pkg::ST_STOP && c_q.bgs_bit && low_s |=> sys_reset) else $error("no bandgap reset");
	bg_quiet_a: assert property (c_q.st == spc_pkg::ST_STOP && !c_q.bgs_bit && !rst_pin_s |=> !sys_reset) else $error("reset without bandgap");
	flash_wait_a: assert property ($rose(cpu_run) |-> $past(c_q.flash_cnt) == '0) else $error("flash warm-up cut short");
	xtal_wait_a: assert property ($rose(cpu_run) && !c_q.ring_sel |-> $past(c_q.xtal_cnt) == '0) else $error("crystal warm-up cut short");
	ring_run_a: assert property ($past(c_q.st) == spc_pkg::ST_STOP && c_q.st == spc_pkg::ST_WARM && c_q.ring_sel |-> clk_from_ring) else $error("ring not used");
	ring_flag_a: assert property (bus_req.rd && bus_req.addr == spc_pkg::REG_IRQ_FLAG |=> bus_rdata[spc_pkg::FLAG_RING_MODE_BIT] == $past(clk_from_ring)) else $error("ring status wrong");
	div_lock_a: assert property (clk_from_ring |-> clk_div == spc_pkg::CLK_DIV_BY1) else $error("divider moved on ring");
	stop_clear_a: assert property (c_q.st == spc_pkg::ST_WARM |-> !c_q.stop_bit) else $error("stop bit not cleared");
	warm_hold_a: assert property (c_q.st == spc_pkg::ST_WARM && !c_q.ring_sel && c_q.xtal_cnt != '0
		|=> c_q.st == spc_pkg::ST_WARM) else $error("left warm-up early");
	ring_hold_a: assert property (clk_from_ring && c_q.st == spc_pkg::ST_WARM && c_q.xtal_cnt != '0
		|=> clk_from_ring) else $error("ring dropped before crystal ready");
	div_write_a: assert property (!clk_from_ring && c_q.st == spc_pkg::ST_RUN && !rst_pin_s && bus_req.wr
		&& bus_req.addr == spc_pkg::REG_CLK_DIV |=> clk_div == $past(bus_req.wdata[1:0])) else $error("divider write lost");
	rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == '0) else $error("read data outside read cycle");

	stop_irq_c: cover property (c_q.st == spc_pkg::ST_STOP && irq_hit ##1 c_q.st == spc_pkg::ST_WARM);
	stop_pin_c: cover property (c_q.st == spc_pkg::ST_STOP && rst_pin_s ##1 sys_reset);
	ring_exit_c: cover property ($fell(clk_from_ring) && cpu_run);
	resume_c: cover property ($rose(cpu_run));
	bg_wake_c: cover property (c_q.st == spc_pkg::ST_STOP && bg_reset ##1 sys_reset);

endmodule : spc_stop_ctrl

`default_nettype wire

// [tb/spc_far_model.sv]
// far-side model: external interrupt pins, reset pin and supply monitor
`default_nettype none

module spc_far_model #(
	parameter logic [5:0] HIGH = spc_pkg::IRQ_HIGH_ACTIVE
) (
	input  wire logic [5:0] irq_act,
	input  wire logic       rst_act,
	input  wire logic       low_act,
	output logic      [5:0] ext_irq_pin,
	output logic            rst_pin,
	output logic            supply_low
);
	timeunit 1ns;
	timeprecision 100ps;

	// each pin shows its own active level only when asserted
	assign ext_irq_pin = ~(irq_act ^ HIGH);
	assign rst_pin     = rst_act;
	assign supply_low  = low_act;
endmodule : spc_far_model

`default_nettype wire

// [tb/stop_mode_power_control_bench.sv]
// bench: register access, stop entry and every wake path
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module stop_mode_power_control_bench;
	timeunit 1ns;
	timeprecision 100ps;

	logic                  core_clk = 1'b0;
	logic                  rst_n    = 1'b0;
	spc_pkg::spc_bus_req_t bus_req  = '0;
	logic [7:0]            bus_rdata;
	logic [5:0]            irq_act  = 6'h00;
	logic                  rst_act  = 1'b0;
	logic                  low_act  = 1'b0;
	logic [5:0]            ext_irq_pin;
	logic                  rst_pin, supply_low, clk_run_en, cpu_run, xtal_en, ring_osc_en, clk_from_ring, sys_reset;
	logic [1:0]            clk_div;
	int                    rst_cnt = 0;
	int                    m;
	int                    bad_count = 0;
	int                    cmp_count = 0;
	int                    n;
	logic [7:0]            d;

	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (sys_reset === 1'b1) rst_cnt <= rst_cnt + 1;

	spc_far_model u_spc_far_model (.irq_act(irq_act), .rst_act(rst_act), .low_act(low_act),
		.ext_irq_pin(ext_irq_pin), .rst_pin(rst_pin), .supply_low(supply_low));

	spc_stop_ctrl #(.FLASH_CYCLES(8), .XTAL_CYCLES(20)) u_spc_stop_ctrl (
		.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.ext_irq_pin(ext_irq_pin), .rst_pin(rst_pin), .supply_low(supply_low),
		.clk_run_en(clk_run_en), .cpu_run(cpu_run), .xtal_en(xtal_en), .ring_osc_en(ring_osc_en),
		.clk_from_ring(clk_from_ring), .sys_reset(sys_reset), .clk_div(clk_div));

	// ----------------------------------------
	// register port and waits
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk) bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk) bus_req <= '0;
	endtask : wr

	task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk) bus_req <= '0;
		#1 d = bus_rdata;
		`CHK(d, e)
	endtask : chk_rd

	// sel 0 cpu_run, 1 clk_run_en, 2 clk_from_ring; n counts edges
	task automatic wait_on(input int sel, input logic want, output int k);
		logic v;
		k = 0;
		v = ~want;
		while (v !== want && k < 60) begin
			@(posedge core_clk);
			#1 k++;
			v = (sel == 0) ? cpu_run : (sel == 1) ? clk_run_en : clk_from_ring;
		end
		`CHK(v, want)
	endtask : wait_on

	task automatic finish_test;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		#40000;
		bad_count++;
		finish_test();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		#1 `CHK({clk_run_en, cpu_run, clk_div}, 4'he)
		chk_rd(4'h0, 8'h00);
		chk_rd(4'h1, 8'h00);
		chk_rd(4'h3, 8'h02);
		chk_rd(4'h7, 8'h00);
		wr(4'h2, 8'h0c);
		wr(4'h0, 8'h02);
		#1 `CHK({cpu_run, clk_run_en, xtal_en, ring_osc_en}, 4'h0)
		@(posedge core_clk) irq_act <= 6'h01;
		repeat (10) @(posedge core_clk);
		#1 `CHK({cpu_run, clk_run_en}, 2'h0)
		@(posedge core_clk) irq_act <= 6'h04;
		wait_on(1, 1'b1, n);
		`CHK(n <= 5, 1'b1)
		wait_on(0, 1'b1, n);
		`CHK(n >= 20 && n <= 22, 1'b1)
		`CHK(clk_from_ring, 1'b0)
		@(posedge core_clk) irq_act <= 6'h00;
		chk_rd(4'h0, 8'h00);
		wr(4'h1, 8'h02);
		wr(4'h0, 8'h02);
		@(posedge core_clk) irq_act <= 6'h04;
		wait_on(1, 1'b1, n);
		`CHK({clk_from_ring, ring_osc_en}, 2'h3)
		wait_on(0, 1'b1, n);
		`CHK(n >= 8 && n <= 10, 1'b1)
		chk_rd(4'h1, 8'h0a);
		wr(4'h3, 8'h03);
		chk_rd(4'h3, 8'h02);
		`CHK(clk_div, 2'h2)
		wait_on(2, 1'b0, n);
		chk_rd(4'h1, 8'h02);
		wr(4'h3, 8'h03);
		chk_rd(4'h3, 8'h03);
		wr(4'h3, 8'h02);
		@(posedge core_clk) irq_act <= 6'h00;
		wr(4'h0, 8'h02);
		@(posedge core_clk) low_act <= 1'b1;
		repeat (10) @(posedge core_clk);
		#1 `CHK({clk_run_en, rst_cnt == 0}, 2'h1)
		@(posedge core_clk) irq_act <= 6'h08;
		wait_on(0, 1'b1, n);
		@(posedge core_clk) irq_act <= 6'h00;
		low_act <= 1'b0;
		wr(4'h0, 8'h42);
		m = rst_cnt;
		@(posedge core_clk) low_act <= 1'b1;
		wait_on(1, 1'b1, n);
		#6 `CHK(rst_cnt - m, 1)
		@(posedge core_clk) low_act <= 1'b0;
		wait_on(0, 1'b1, n);
		wr(4'h0, 8'h02);
		m = rst_cnt;
		@(posedge core_clk) rst_act <= 1'b1;
		wait_on(1, 1'b1, n);
		#6 `CHK(rst_cnt - m, 1)
		@(posedge core_clk) rst_act <= 1'b0;
		wait_on(0, 1'b1, n);
		chk_rd(4'h0, 8'h00);
		finish_test();
	end
endmodule : stop_mode_power_control_bench

`default_nettype wire
